// ---- logic/bhtr_pkg.sv ----
// Constants for the bridge header tail register bank (offsets 2Ch..3Ch).
// Assumes an APB master with 32-bit data and byte addresses on paddr.
package bhtr_pkg;
  // Register byte offsets
  localparam logic [7:0]  ADDR_PREFETCH_TOP_HIGH = 8'h2c;
  localparam logic [7:0]  ADDR_IO_WINDOW_HIGH    = 8'h30;
  localparam logic [7:0]  ADDR_CAPABILITY_HEAD   = 8'h34;
  localparam logic [7:0]  ADDR_OPTION_ROM        = 8'h38;
  localparam logic [7:0]  ADDR_IRQ_AND_CONTROL   = 8'h3c;
  // Reset and fixed values
  localparam logic [31:0] RESET_WORD             = 32'h0000_0000;
  localparam logic [15:0] RESET_HALF             = 16'h0000;
  localparam logic [7:0]  RESET_BYTE             = 8'h00;
  localparam logic [7:0]  CAPABILITY_HEAD_VALUE  = 8'h80;
  localparam logic [7:0]  IRQ_PIN_VALUE          = 8'h01;
  // Bridge control field positions inside the 16-bit control half
  localparam int          BC_PARITY_EN           = 0;
  localparam int          BC_SERR_EN             = 1;
  localparam int          BC_ISA_EN              = 2;
  localparam int          BC_VGA_EN              = 3;
  localparam int          BC_VGA_16BIT           = 4;
  localparam int          BC_ABORT_MODE          = 5;
  localparam int          BC_SEC_RESET           = 6;
  localparam int          BC_FAST_B2B            = 7;
  localparam int          BC_PRI_TIMEOUT         = 8;
  localparam int          BC_SEC_TIMEOUT         = 9;
  localparam int          BC_TIMEOUT_STATUS      = 10;
  localparam int          BC_TIMEOUT_SERR_EN     = 11;
  // Writable control bits in both modes, plus the mode-dependent ones
  localparam logic [15:0] BC_WRITE_COMMON        = 16'h087d;
  localparam logic [15:0] BC_WRITE_FORWARD       = 16'h0202;
  localparam logic [15:0] BC_WRITE_REVERSE       = 16'h0100;
  // Graphics compatible ranges
  localparam logic [14:0] VGA_MEM_PAGE           = 15'h0005;
  localparam logic [9:0]  VGA_IO_MONO_LO         = 10'h3b0;
  localparam logic [9:0]  VGA_IO_MONO_HI         = 10'h3bb;
  localparam logic [9:0]  VGA_IO_COLOR_LO        = 10'h3c0;
  localparam logic [9:0]  VGA_IO_COLOR_HI        = 10'h3df;
  // Discard timer lengths in parallel-bus clocks (2^10 and 2^15)
  localparam int          DISCARD_SHORT_CYCLES   = 1024;
  localparam int          DISCARD_LONG_CYCLES    = 32768;
  localparam int          DISCARD_COUNT_W        = 16;
endpackage

// ---- logic/bhtr_timer_if.sv ----
// Link between the register bank and its discard timer.
// Both ends sit on the same clock.
`timescale 1ns/100ps
interface bhtr_timer_if;
  logic start;     // Delayed completion queued, pulse
  logic stop;      // Completion taken by its master, pulse
  logic short_sel; // Use the short discard length
  logic expired;   // Timer ran out, pulse
  modport bank  (output start, output stop, output short_sel, input expired);
  modport timer (input start, input stop, input short_sel, output expired);
endinterface

// ---- logic/bhtr_discard_timer.sv ----
// Discard timer for one delayed completion.
// Assumes start and stop are single-cycle pulses from the register bank.
`timescale 1ns/100ps
module bhtr_discard_timer
  import bhtr_pkg::*;
#(
  parameter int P_LONG_CYCLES = DISCARD_LONG_CYCLES
) (
  input  wire logic   i_clk,     // Bridge clock
  input  wire logic   i_reset_n, // Synchronous reset, active low
  bhtr_timer_if.timer tmr        // Control from the bank
);
  logic                       running;
  logic                       next_running;
  logic [DISCARD_COUNT_W-1:0] count;
  logic [DISCARD_COUNT_W-1:0] next_count;
  logic                       expired;
  logic                       next_expired;

  // Load on start, count down, fire once at zero; a new start restarts
  always_comb begin
    next_running = running;
    next_count   = count;
    next_expired = 1'b0;
    if (tmr.start) begin
      next_running = 1'b1;
      next_count   = tmr.short_sel ? DISCARD_COUNT_W'(DISCARD_SHORT_CYCLES - 1)
                                   : DISCARD_COUNT_W'(P_LONG_CYCLES - 1);
    end else if (tmr.stop) begin
      next_running = 1'b0;
    end else if (running) begin
      if (count == '0) begin
        next_running = 1'b0;
        next_expired = 1'b1;
      end else begin
        next_count = count - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      running <= 1'b0;
      count   <= '0;
      expired <= 1'b0;
    end else begin
      running <= next_running;
      count   <= next_count;
      expired <= next_expired;
    end
  end

  assign tmr.expired = expired;
endmodule

// ---- logic/bhtr_regs.sv ----
// Bridge header tail register bank: upper window halves, capability pointer,
// option ROM, interrupt line/pin and bridge control, plus the behaviour they steer.
// Assumes an APB master on i_clk; event inputs are one-cycle pulses on i_clk,
// while the mode strap and the secondary error pin come straight from pins.
`timescale 1ns/100ps
module bhtr_regs
  import bhtr_pkg::*;
#(
  parameter int P_DISCARD_LONG_CYCLES = DISCARD_LONG_CYCLES
) (
  input  wire logic        i_clk,                        // Bridge clock, 20 MHz
  input  wire logic        i_reset_n,                    // Synchronous reset, active low
  input  wire logic        i_psel,                       // APB select
  input  wire logic        i_penable,                    // APB enable
  input  wire logic        i_pwrite,                     // APB write
  input  wire logic [7:0]  i_paddr,                      // APB byte address
  input  wire logic [31:0] i_pwdata,                     // APB write data
  output logic      [31:0] o_prdata,                     // APB read data
  output logic             o_pready,                     // APB ready
  output logic             o_pslverr,                    // APB error, unmapped offset
  input  wire logic        i_reverse_mode,               // Strap pin, high for reverse bridge
  input  wire logic        i_system_error_pin_n,         // Secondary error pin, active low
  input  wire logic        i_poisoned_packet,            // Poisoned packet from link
  input  wire logic        i_secondary_bus_error,        // Uncorrectable secondary bus error
  input  wire logic        i_master_abort,               // Master abort seen
  input  wire logic        i_master_abort_read,          // That abort was a read
  input  wire logic        i_target_abort_possible,      // Target abort can be signalled
  input  wire logic        i_serr_report_enable,         // System error reporting enabled
  input  wire logic        i_io_enable,                  // I/O space enable
  input  wire logic        i_mem_enable,                 // Memory space enable
  input  wire logic        i_decode_valid,               // Address to decode, pulse
  input  wire logic        i_decode_is_io,               // Address is I/O space
  input  wire logic [31:0] i_decode_addr,                // Address to decode
  input  wire logic        i_completion_queued,          // Delayed completion stored
  input  wire logic        i_completion_taken,           // Delayed completion collected
  output logic      [31:0] o_prefetch_window_top_high,   // Prefetch limit bits 63:32
  output logic      [7:0]  o_irq_routing_note,           // Software routing note
  output logic             o_forward_valid,              // Decode answer valid, pulse
  output logic             o_forward_downstream,         // Pass address to secondary
  output logic             o_master_parity_error_set,    // Set parity status, pulse
  output logic             o_parity_error_respond,       // Respond to bus error, pulse
  output logic             o_error_message_req,          // Send error message, pulse
  output logic             o_signal_target_abort,        // Report abort as target abort
  output logic             o_abort_read_all_ones,        // Return all ones to the aborted read
  output logic             o_primary_system_error_pin_n, // Primary error pin, active low
  output logic             o_secondary_reset_n,          // Secondary bus reset, active low
  output logic             o_link_hot_reset,             // Hot reset onto the link
  output logic             o_completion_discarded        // Completion thrown away, pulse
);
  // Two-stage synchronisers for the strap and the error pin
  logic [1:0] pin_async;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  assign pin_async = {i_system_error_pin_n, i_reverse_mode};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
          pin_meta[gi] <= 1'b1;
          pin_sync[gi] <= 1'b1;
        end else begin
          pin_meta[gi] <= pin_async[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic reverse;
  logic serr_pin_n;
  logic serr_pin_n_d;
  assign reverse    = pin_sync[0];
  assign serr_pin_n = pin_sync[1];

  bhtr_timer_if tmr ();

  bhtr_discard_timer #(
    .P_LONG_CYCLES (P_DISCARD_LONG_CYCLES)
  ) u_timer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .tmr       (tmr)
  );

  // Register state
  logic [31:0] pref_top_high;
  logic [31:0] next_pref_top_high;
  logic [15:0] io_bottom_high;
  logic [15:0] next_io_bottom_high;
  logic [15:0] io_top_high;
  logic [15:0] next_io_top_high;
  logic [7:0]  irq_note;
  logic [7:0]  next_irq_note;
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic [15:0] wr_mask;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        access;
  logic        wr_ctrl;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  // One wait state: the access is taken on the edge that raises pready
  assign access  = i_psel && i_penable && !o_pready;
  assign wr_ctrl = access && i_pwrite && (i_paddr == ADDR_IRQ_AND_CONTROL);
  assign wr_mask = BC_WRITE_COMMON | (reverse ? BC_WRITE_REVERSE : BC_WRITE_FORWARD);

  // Read mux; fixed words are constants, so writes to them cannot land
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = RESET_WORD;
    unique case (i_paddr)
      ADDR_PREFETCH_TOP_HIGH: rd_word = pref_top_high;
      ADDR_IO_WINDOW_HIGH:    rd_word = {io_top_high, io_bottom_high};
      ADDR_CAPABILITY_HEAD:   rd_word = {24'h00_0000, CAPABILITY_HEAD_VALUE};
      ADDR_OPTION_ROM:        rd_word = RESET_WORD;
      ADDR_IRQ_AND_CONTROL:   rd_word = {ctrl, IRQ_PIN_VALUE, irq_note};
      default:                rd_hit  = 1'b0;
    endcase
  end

  // APB answer path
  always_comb begin
    next_pready  = access;
    next_prdata  = o_prdata;
    next_pslverr = 1'b0;
    if (access) begin
      next_prdata  = i_pwrite ? RESET_WORD : rd_word;
      next_pslverr = !rd_hit;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= RESET_WORD;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= next_pready;
      o_prdata  <= next_prdata;
      o_pslverr <= next_pslverr;
    end
  end

  // Software writes; masked control bits keep read-only fields at zero
  always_comb begin
    next_pref_top_high  = pref_top_high;
    next_io_bottom_high = io_bottom_high;
    next_io_top_high    = io_top_high;
    next_irq_note       = irq_note;
    next_ctrl           = ctrl;
    if (access && i_pwrite) begin
      if (i_paddr == ADDR_PREFETCH_TOP_HIGH) begin
        next_pref_top_high = i_pwdata;
      end
      if (i_paddr == ADDR_IO_WINDOW_HIGH) begin
        next_io_bottom_high = i_pwdata[15:0];
        next_io_top_high    = i_pwdata[31:16];
      end
    end
    if (wr_ctrl) begin
      next_irq_note = i_pwdata[7:0];
      next_ctrl     = (ctrl & ~wr_mask) | (i_pwdata[31:16] & wr_mask);
    end
    // Expiry wins over a clearing write in the same cycle
    next_ctrl[BC_TIMEOUT_STATUS] = tmr.expired ||
      (ctrl[BC_TIMEOUT_STATUS] && !(wr_ctrl && i_pwdata[16 + BC_TIMEOUT_STATUS]));
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pref_top_high  <= RESET_WORD;
      io_bottom_high <= RESET_HALF;
      io_top_high    <= RESET_HALF;
      irq_note       <= RESET_BYTE;
      ctrl           <= RESET_HALF;
    end else begin
      pref_top_high  <= next_pref_top_high;
      io_bottom_high <= next_io_bottom_high;
      io_top_high    <= next_io_top_high;
      irq_note       <= next_irq_note;
      ctrl           <= next_ctrl;
    end
  end

  // Only the timer of the active direction matters, so one timer serves both
  assign tmr.start     = i_completion_queued;
  assign tmr.stop      = i_completion_taken;
  assign tmr.short_sel = reverse ? ctrl[BC_PRI_TIMEOUT] : ctrl[BC_SEC_TIMEOUT];

  // Address decode: windows use the upper I/O halves only
  logic       in_io_window;
  logic       isa_upstream;
  logic       vga_io_hit;
  logic       vga_mem_hit;
  logic       vga_forward;
  logic [9:0] io_low;
  assign io_low       = i_decode_addr[9:0];
  assign in_io_window = (i_decode_addr[31:16] >= io_bottom_high) && (i_decode_addr[31:16] <= io_top_high);
  assign isa_upstream = ctrl[BC_ISA_EN] && (i_decode_addr[31:16] == RESET_HALF) &&
                        (i_decode_addr[9:8] != 2'b00);
  assign vga_io_hit   = ((io_low >= VGA_IO_MONO_LO && io_low <= VGA_IO_MONO_HI) ||
                         (io_low >= VGA_IO_COLOR_LO && io_low <= VGA_IO_COLOR_HI)) &&
                        (!ctrl[BC_VGA_16BIT] || i_decode_addr[31:10] == 22'h00_0000);
  assign vga_mem_hit  = (i_decode_addr[31:17] == VGA_MEM_PAGE);
  assign vga_forward  = ctrl[BC_VGA_EN] &&
                        (i_decode_is_io ? (vga_io_hit && i_io_enable) : (vga_mem_hit && i_mem_enable));

  // Event responses, each registered so every output leaves a flip-flop
  logic next_forward_valid;
  logic next_forward_downstream;
  logic next_parity_set;
  logic next_parity_respond;
  logic next_error_message;
  logic next_target_abort;
  logic next_all_ones;
  logic next_primary_serr_n;
  logic next_discarded;
  logic serr_fell;
  assign serr_fell = serr_pin_n_d && !serr_pin_n;

  always_comb begin
    next_forward_valid      = i_decode_valid;
    next_forward_downstream = o_forward_downstream;
    if (i_decode_valid) begin
      next_forward_downstream = vga_forward ||
        (i_decode_is_io && i_io_enable && in_io_window && !isa_upstream);
    end
    next_parity_set     = reverse && i_poisoned_packet && ctrl[BC_PARITY_EN];
    next_parity_respond = !reverse && i_secondary_bus_error && ctrl[BC_PARITY_EN];
    next_error_message  = (!reverse && serr_fell && ctrl[BC_SERR_EN]) ||
                          (!reverse && tmr.expired && ctrl[BC_TIMEOUT_SERR_EN]);
    next_all_ones       = i_master_abort && !ctrl[BC_ABORT_MODE] && i_master_abort_read;
    next_target_abort   = i_master_abort && ctrl[BC_ABORT_MODE] && i_target_abort_possible;
    next_primary_serr_n = !((i_master_abort && ctrl[BC_ABORT_MODE] &&
                             !i_target_abort_possible && i_serr_report_enable) ||
                            (reverse && tmr.expired && ctrl[BC_TIMEOUT_SERR_EN]));
    next_discarded      = tmr.expired;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_forward_valid              <= 1'b0;
      o_forward_downstream         <= 1'b0;
      o_master_parity_error_set    <= 1'b0;
      o_parity_error_respond       <= 1'b0;
      o_error_message_req          <= 1'b0;
      o_signal_target_abort        <= 1'b0;
      o_abort_read_all_ones        <= 1'b0;
      o_primary_system_error_pin_n <= 1'b1;
      o_completion_discarded       <= 1'b0;
      serr_pin_n_d                 <= 1'b1;
    end else begin
      o_forward_valid              <= next_forward_valid;
      o_forward_downstream         <= next_forward_downstream;
      o_master_parity_error_set    <= next_parity_set;
      o_parity_error_respond       <= next_parity_respond;
      o_error_message_req          <= next_error_message;
      o_signal_target_abort        <= next_target_abort;
      o_abort_read_all_ones        <= next_all_ones;
      o_primary_system_error_pin_n <= next_primary_serr_n;
      o_completion_discarded       <= next_discarded;
      serr_pin_n_d                 <= serr_pin_n;
    end
  end

  // Reset drive follows the control bit in the active direction
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_secondary_reset_n <= 1'b1;
      o_link_hot_reset    <= 1'b0;
    end else begin
      o_secondary_reset_n <= !(ctrl[BC_SEC_RESET] && !reverse);
      o_link_hot_reset    <= ctrl[BC_SEC_RESET] && reverse;
    end
  end

  assign o_prefetch_window_top_high = pref_top_high;
  assign o_irq_routing_note         = irq_note;

  // Checks on the bank's own behaviour
  AST_PREF_WRITE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    access && i_pwrite && i_paddr == ADDR_PREFETCH_TOP_HIGH |=> o_prefetch_window_top_high == $past(i_pwdata))
    else $error("Prefetch limit upper word not written");
  AST_CAP_READ: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    access && !i_pwrite && i_paddr == ADDR_CAPABILITY_HEAD |=> o_pready && o_prdata == 32'h0000_0080)
    else $error("Capability pointer read wrong");
  AST_ROM_READ: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    access && !i_pwrite && i_paddr == ADDR_OPTION_ROM |=> o_pready && o_prdata == 32'h0000_0000)
    else $error("Option ROM word not zero");
  AST_PIN_READ: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    access && !i_pwrite && i_paddr == ADDR_IRQ_AND_CONTROL |=> o_prdata[15:8] == 8'h01 && o_prdata[31:28] == 4'h0)
    else $error("Interrupt pin or reserved bits wrong");
  AST_FBB_ZERO: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ##1 !ctrl[BC_FAST_B2B])
    else $error("Fast back-to-back bit became set");
  AST_POISON: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_poisoned_packet && reverse && ctrl[BC_PARITY_EN] |=> o_master_parity_error_set)
    else $error("Poisoned packet not flagged");
  AST_SEC_RESET: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ctrl[BC_SEC_RESET] && !reverse ##1 ctrl[BC_SEC_RESET] && !reverse |-> !o_secondary_reset_n && !o_link_hot_reset)
    else $error("Secondary reset not held");
  AST_STATUS_SET: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    tmr.expired |=> ctrl[BC_TIMEOUT_STATUS] && o_completion_discarded)
    else $error("Discard status not set");
  AST_ALL_ONES: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_master_abort && i_master_abort_read && !ctrl[BC_ABORT_MODE] |=> o_abort_read_all_ones && !o_signal_target_abort)
    else $error("Hidden master abort not answered with all ones");
  // A control-word write must load its low byte into the interrupt routing note
  AST_NOTE_WRITE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wr_ctrl |=> o_irq_routing_note == $past(i_pwdata[7:0]))
    else $error("Interrupt routing note not written");
  AST_IO_WRITE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    access && i_pwrite && i_paddr == ADDR_IO_WINDOW_HIGH |=> {io_top_high, io_bottom_high} == $past(i_pwdata))
    else $error("Upper I/O base or limit not written");
  AST_PARITY_FWD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_secondary_bus_error && !reverse && ctrl[BC_PARITY_EN] |=> o_parity_error_respond)
    else $error("Secondary bus error not answered");
  AST_SERR_FWD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    serr_fell && !reverse && ctrl[BC_SERR_EN] |=> o_error_message_req)
    else $error("Secondary error pin not forwarded");
  AST_PRI_TIMER_RO: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wr_ctrl && !reverse |=> $stable(ctrl[BC_PRI_TIMEOUT]))
    else $error("Primary discard select written in forward mode");
  AST_SEC_TIMER_RO: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wr_ctrl && reverse |=> $stable(ctrl[BC_SEC_TIMEOUT]) && $stable(ctrl[BC_SERR_EN]))
    else $error("Forward-only control bit written in reverse mode");
  AST_HOT_RESET: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ctrl[BC_SEC_RESET] && reverse ##1 ctrl[BC_SEC_RESET] && reverse |-> o_link_hot_reset && o_secondary_reset_n)
    else $error("Hot reset not driven");
  AST_ABORT_PIN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_master_abort && ctrl[BC_ABORT_MODE] && !i_target_abort_possible && i_serr_report_enable
      |=> !o_primary_system_error_pin_n && !o_signal_target_abort)
    else $error("Master abort not reported on the error pin");
  AST_VGA_IO: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_decode_valid && i_decode_is_io && i_io_enable && ctrl[BC_VGA_EN] && vga_io_hit |=> o_forward_downstream)
    else $error("Graphics I/O address not forwarded");
endmodule

// ---- verif/bridge_header_tail_regs_bench.sv ----
// Self-checking bench for the bridge header tail register bank.
// Assumes the bank answers APB with one wait state and registers its event pulses.
`timescale 1ns/100ps
module bridge_header_tail_regs_bench;
  localparam int LONG = 64; // Shortened long discard length keeps the run brief
  logic        i_clk = 1'b0, i_reset_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, err;
  logic [7:0]  i_paddr = 8'h00, note;
  logic [31:0] i_pwdata = 32'h0000_0000, rd, o_prdata, top_high, da = 32'h0000_0000;
  logic        rev = 1'b0, poison = 1'b0, abort = 1'b0, ta_ok = 1'b1, queued = 1'b0, o_pready, o_pslverr;
  logic        serr_n = 1'b1, bus_err = 1'b0, rd_ab = 1'b1, srep = 1'b0, ioe = 1'b0, meme = 1'b0;
  logic        dv = 1'b0, dio = 1'b0, taken = 1'b0, par_set, tabort, ones, sec_n, hot, disc;
  logic        fwd_v, fwd_dn, par_rsp, emsg, pserr_n;
  int          mismatches = 0, checks_done = 0, k;

  bhtr_regs #(.P_DISCARD_LONG_CYCLES(LONG)) uut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_reverse_mode(rev), .i_system_error_pin_n(serr_n), .i_poisoned_packet(poison),
    .i_secondary_bus_error(bus_err), .i_master_abort(abort), .i_master_abort_read(rd_ab),
    .i_target_abort_possible(ta_ok), .i_serr_report_enable(srep), .i_io_enable(ioe), .i_mem_enable(meme),
    .i_decode_valid(dv), .i_decode_is_io(dio), .i_decode_addr(da), .i_completion_queued(queued),
    .i_completion_taken(taken), .o_prefetch_window_top_high(top_high), .o_irq_routing_note(note),
    .o_forward_valid(fwd_v), .o_forward_downstream(fwd_dn), .o_master_parity_error_set(par_set),
    .o_parity_error_respond(par_rsp), .o_error_message_req(emsg), .o_signal_target_abort(tabort),
    .o_abort_read_all_ones(ones), .o_primary_system_error_pin_n(pserr_n), .o_secondary_reset_n(sec_n),
    .o_link_hot_reset(hot), .o_completion_discarded(disc));

  // Free-running 20 MHz clock
  always #25 i_clk = ~i_clk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    // Outputs launched by the answer edge only settle after it
    @(posedge i_clk);
    if (n >= 20) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // One-cycle event pulse; outputs are settled just after the sampling edge
  task automatic fire(input int which);
    @(posedge i_clk);
    abort <= (which == 0);
    poison <= (which == 1);
    queued <= (which == 2);
    bus_err <= (which == 3);
    @(posedge i_clk);
    abort <= 1'b0;
    poison <= 1'b0;
    queued <= 1'b0;
    bus_err <= 1'b0;
    #1;
  endtask

  // One I/O decode request; answer is registered one cycle later
  task automatic decode(input logic [31:0] a, input logic e);
    @(posedge i_clk);
    dv <= 1'b1;
    dio <= 1'b1;
    da <= a;
    @(posedge i_clk);
    dv <= 1'b0;
    #1;
    chk(fwd_v, 1'b1);
    chk(fwd_dn, e);
  endtask

  // Start a delayed completion and count cycles until it is discarded
  task automatic wait_disc(input int exp);
    fire(2);
    k = 0;
    while (disc !== 1'b1 && k < 1200) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    chk(k, exp);
  endtask

  task automatic reset_values;
    rdchk(8'h2c, 32'h0000_0000);
    rdchk(8'h30, 32'h0000_0000);
    rdchk(8'h34, 32'h0000_0080);
    rdchk(8'h38, 32'h0000_0000);
    rdchk(8'h3c, 32'h0000_0100);
    rdchk(8'h40, 32'h0000_0000);
    chk(err, 1'b1);
  endtask

  // Forward mode: only forward-writable control bits take; reserved bits stay zero
  task automatic forward_control;
    apb(1'b1, 8'h3c, 32'hffff_ffff);
    rdchk(8'h3c, 32'h0a7f_01ff);
    chk(note, 8'hff);
    fire(3);
    chk(par_rsp, 1'b1);
    @(posedge i_clk);
    serr_n <= 1'b0;
    ioe <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    chk(emsg, 1'b1);
    decode(32'h0000_03c0, 1'b1);
    decode(32'h0000_07c0, 1'b0);
    decode(32'h0000_0100, 1'b0);
    decode(32'h0000_0000, 1'b1);
    @(posedge i_clk);
    serr_n <= 1'b1;
    chk(sec_n, 1'b0);
    chk(hot, 1'b0);
    apb(1'b1, 8'h2c, 32'hdead_beef);
    apb(1'b1, 8'h30, 32'h1234_5678);
    apb(1'b1, 8'h34, 32'hffff_ffff);
    apb(1'b1, 8'h38, 32'hffff_ffff);
    rdchk(8'h2c, 32'hdead_beef);
    chk(top_high, 32'hdead_beef);
    rdchk(8'h30, 32'h1234_5678);
    rdchk(8'h34, 32'h0000_0080);
    rdchk(8'h38, 32'h0000_0000);
    apb(1'b1, 8'h3c, 32'h0000_0000);
    chk(sec_n, 1'b1);
  endtask

  // Reverse mode: abort handling, poisoned packets and hot reset
  task automatic reverse_events;
    rev <= 1'b1;
    repeat (4) @(posedge i_clk);
    fire(0);
    chk(ones, 1'b1);
    apb(1'b1, 8'h3c, 32'h0061_0000);
    chk(hot, 1'b1);
    fire(0);
    chk(tabort, 1'b1);
    chk(ones, 1'b0);
    fire(1);
    chk(par_set, 1'b1);
    @(posedge i_clk);
    ta_ok <= 1'b0;
    srep <= 1'b1;
    fire(0);
    chk(pserr_n, 1'b0);
    chk(tabort, 1'b0);
    apb(1'b1, 8'h3c, 32'h0000_0000);
    chk(hot, 1'b0);
  endtask

  // Long discard expiry, sticky status and write-one-to-clear
  task automatic discard_timer;
    apb(1'b1, 8'h3c, 32'h0800_0000);
    wait_disc(LONG + 1);
    chk(pserr_n, 1'b0);
    rdchk(8'h3c, 32'h0c00_0100);
    apb(1'b1, 8'h3c, 32'h0000_0000);
    rdchk(8'h3c, 32'h0400_0100);
    apb(1'b1, 8'h3c, 32'h0500_0000);
    rdchk(8'h3c, 32'h0100_0100);
    wait_disc(1024 + 1);
  endtask

  initial begin
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    reset_values();
    forward_control();
    reverse_events();
    discard_timer();
    report_and_stop();
  end
endmodule
